// ### core/sbac_ctrl.sv
// Purpose: Register side of the serial bus byte access controller
// Assumes: Configuration port on the core clock; strap and reset pins async
// Notes:   Preload and software cycles share one byte engine
//
// Operation
// - Target-select write launches one serial cycle
// - Target-select resets to A0h
// - Bits 7:1 hold target address
// - Bit 0: 0 writes, 1 reads
// - Control bit 7 drops the index phase
// - Control bits 6 and 2 read zero
// - Bit 5 shows software cycle active
// - Bit 4 shows EEPROM preload running
// - Bit 3 set when strap shows EEPROM
// - Bit 3 enables software cycles; preload starts from the strap
// - Detection once per fundamental or global reset
// - Software may set bit 3 itself
// - All fields default on fundamental reset
// - Read data lands in the same cycle busy clears
// - Bit 1 sticky error, cleared by read
`timescale 1ns/1ps
module sbac_ctrl
  import sbac_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  input  wire logic       global_reset_n,
  input  wire logic       prom_strap,
  input  wire logic       cfg_wr_en,
  input  wire logic       cfg_rd_en,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] cfg_wdata,
  output logic      [7:0] cfg_rdata,
  output logic            scl_out,
  output logic            scl_oe,
  input  wire logic       scl_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       sda_in,
  output logic            preload_valid,
  output logic      [7:0] preload_index,
  output logic      [7:0] preload_data
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] data_reg, next_data_reg;
  logic [7:0] index_reg, next_index_reg;
  logic [7:0] target, next_target;
  logic       address_phase_select, next_address_phase_select;
  logic       prom_present, next_prom_present;
  logic       host_cycle_active, next_host_cycle_active;
  logic       preload_active, next_preload_active;
  logic       host_cycle_error, next_host_cycle_error;
  logic       preload_error, next_preload_error;
  logic       wait_rsp, next_wait_rsp;
  logic [1:0] detect_wait, next_detect_wait;
  logic [7:0] pre_idx, next_pre_idx;
  logic       eng_start, next_eng_start;
  sbac_req_s  eng_req, next_eng_req;
  logic [7:0] next_cfg_rdata;
  logic       next_preload_valid;
  logic [7:0] next_preload_index, next_preload_data;
  sbac_rsp_s  eng_rsp;
  logic [1:0] strap_sync, global_reset_n_sync;
  logic       global_reset_n_prev;
  logic       idle, rd_ctrl;
  logic [7:0] ctrl_view;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      strap_sync <= 2'h0;
      global_reset_n_sync  <= 2'h3;
      global_reset_n_prev  <= 1'b1;
    end else begin
      strap_sync <= {strap_sync[0], prom_strap};
      global_reset_n_sync  <= {global_reset_n_sync[0], global_reset_n};
      global_reset_n_prev  <= global_reset_n_sync[1];
    end
  end

  // ----------------------------------------------------------------
  // Register file, detection and cycle control
  // ----------------------------------------------------------------
  assign idle    = !host_cycle_active && !preload_active && !wait_rsp && !eng_start;
  assign rd_ctrl = cfg_rd_en && cfg_addr == SBAC_OFS_CTRL;

  always_comb begin
    ctrl_view = 8'h00;
    ctrl_view[SBAC_BIT_PHASE]   = address_phase_select;
    ctrl_view[SBAC_BIT_HBUSY]   = host_cycle_active;
    ctrl_view[SBAC_BIT_PBUSY]   = preload_active;
    ctrl_view[SBAC_BIT_PRESENT] = prom_present;
    ctrl_view[SBAC_BIT_HERR]    = host_cycle_error;
    ctrl_view[SBAC_BIT_PERR]    = preload_error;
  end

  always_comb begin
    next_data_reg             = data_reg;
    next_index_reg            = index_reg;
    next_target               = target;
    next_address_phase_select = address_phase_select;
    next_prom_present         = prom_present;
    next_host_cycle_active    = host_cycle_active;
    next_preload_active       = preload_active;
    next_host_cycle_error     = host_cycle_error;
    next_preload_error        = preload_error;
    next_wait_rsp             = wait_rsp;
    next_detect_wait          = detect_wait;
    next_pre_idx              = pre_idx;
    next_eng_start            = 1'b0;
    next_eng_req              = eng_req;
    next_cfg_rdata            = cfg_rdata;
    next_preload_valid        = 1'b0;
    next_preload_index        = preload_index;
    next_preload_data         = preload_data;

    if (cfg_rd_en) begin
      unique case (cfg_addr)
        SBAC_OFS_DATA:   next_cfg_rdata = data_reg;
        SBAC_OFS_INDEX:  next_cfg_rdata = index_reg;
        SBAC_OFS_TARGET: next_cfg_rdata = target;
        SBAC_OFS_CTRL:   next_cfg_rdata = ctrl_view;
        default:         next_cfg_rdata = 8'h00;
      endcase
    end
    if (rd_ctrl) begin
      next_host_cycle_error = 1'b0;
      next_preload_error    = 1'b0;
    end

    if (cfg_wr_en) begin
      unique case (cfg_addr)
        SBAC_OFS_DATA:  next_data_reg  = cfg_wdata;
        SBAC_OFS_INDEX: next_index_reg = cfg_wdata;
        SBAC_OFS_TARGET: begin
          next_target = cfg_wdata;
          // Launch needs the bus enabled and no cycle in flight
          if (prom_present && idle) begin
            next_eng_req.addr      = cfg_wdata[7:1];
            next_eng_req.rd        = cfg_wdata[0];
            next_eng_req.addr_only = address_phase_select;
            next_eng_req.index     = index_reg;
            next_eng_req.wdata     = data_reg;
            next_eng_start         = 1'b1;
            next_host_cycle_active = 1'b1;
            next_wait_rsp          = 1'b1;
          end
        end
        SBAC_OFS_CTRL: begin
          next_address_phase_select = cfg_wdata[SBAC_BIT_PHASE];
          next_prom_present         = cfg_wdata[SBAC_BIT_PRESENT];
        end
        default: next_data_reg = data_reg;
      endcase
    end

    // Global reset restarts detection only; fields keep their values
    if (global_reset_n_prev && !global_reset_n_sync[1]) begin
      next_detect_wait = SBAC_DETECT_WAIT;
    end else if (detect_wait != 2'h0) begin
      next_detect_wait = detect_wait - 2'h1;
      if (detect_wait == 2'h1) begin
        next_prom_present = strap_sync[1];
        if (strap_sync[1] && !preload_active) begin
          next_preload_active = 1'b1;
          next_pre_idx        = 8'h00;
        end
      end
    end

    if (preload_active && !wait_rsp && !eng_start && !host_cycle_active) begin
      next_eng_req.addr      = SBAC_PRELOAD_ADDR;
      next_eng_req.rd        = 1'b1;
      next_eng_req.addr_only = 1'b0;
      next_eng_req.index     = pre_idx;
      next_eng_req.wdata     = 8'h00;
      next_eng_start         = 1'b1;
      next_wait_rsp          = 1'b1;
    end

    if (eng_rsp.done) begin
      next_wait_rsp = 1'b0;
      if (host_cycle_active) begin
        next_host_cycle_active = 1'b0;
        if (eng_rsp.err) begin
          next_host_cycle_error = 1'b1;
        end
        if (eng_req.rd) begin
          next_data_reg = eng_rsp.rdata;
        end
      end else begin
        next_preload_valid = !eng_rsp.err;
        next_preload_index = pre_idx;
        next_preload_data  = eng_rsp.rdata;
        next_pre_idx       = pre_idx + 8'h01;
        if (eng_rsp.err) begin
          next_preload_error  = 1'b1;
          next_preload_active = 1'b0;
        end else if (pre_idx == SBAC_PRELOAD_LAST) begin
          next_preload_active = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      data_reg             <= SBAC_DATA_RST;
      index_reg            <= SBAC_INDEX_RST;
      target               <= SBAC_TARGET_RST;
      address_phase_select <= SBAC_CTRL_RST[SBAC_BIT_PHASE];
      prom_present         <= SBAC_CTRL_RST[SBAC_BIT_PRESENT];
      host_cycle_active    <= SBAC_CTRL_RST[SBAC_BIT_HBUSY];
      preload_active       <= SBAC_CTRL_RST[SBAC_BIT_PBUSY];
      host_cycle_error     <= SBAC_CTRL_RST[SBAC_BIT_HERR];
      preload_error        <= SBAC_CTRL_RST[SBAC_BIT_PERR];
      wait_rsp             <= 1'b0;
      detect_wait          <= SBAC_DETECT_WAIT;
      pre_idx              <= 8'h00;
      eng_start            <= 1'b0;
      eng_req              <= '0;
      cfg_rdata            <= 8'h00;
      preload_valid        <= 1'b0;
      preload_index        <= 8'h00;
      preload_data         <= 8'h00;
    end else begin
      data_reg             <= next_data_reg;
      index_reg            <= next_index_reg;
      target               <= next_target;
      address_phase_select <= next_address_phase_select;
      prom_present         <= next_prom_present;
      host_cycle_active    <= next_host_cycle_active;
      preload_active       <= next_preload_active;
      host_cycle_error     <= next_host_cycle_error;
      preload_error        <= next_preload_error;
      wait_rsp             <= next_wait_rsp;
      detect_wait          <= next_detect_wait;
      pre_idx              <= next_pre_idx;
      eng_start            <= next_eng_start;
      eng_req              <= next_eng_req;
      cfg_rdata            <= next_cfg_rdata;
      preload_valid        <= next_preload_valid;
      preload_index        <= next_preload_index;
      preload_data         <= next_preload_data;
    end
  end

  // ----------------------------------------------------------------
  // Byte engine
  // ----------------------------------------------------------------
  sbac_engine u_engine (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .start    (eng_start),
    .req_in   (eng_req),
    .rsp      (eng_rsp),
    .scl_out  (scl_out),
    .scl_oe   (scl_oe),
    .scl_in   (scl_in),
    .sda_out  (sda_out),
    .sda_oe   (sda_oe),
    .sda_in   (sda_in)
  );

endmodule

// ### core/sbac_pkg.sv
// Purpose: Shared constants and types for the serial bus byte access controller
// Assumes: Byte-wide configuration port at the register offsets below
// Notes:   Serial bus timing is a plain standard-mode default
package sbac_pkg;

  // ----------------------------------------------------------------
  // Register offsets and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] SBAC_OFS_DATA   = 8'hB0;
  localparam logic [7:0] SBAC_OFS_INDEX  = 8'hB1;
  localparam logic [7:0] SBAC_OFS_TARGET = 8'hB2;
  localparam logic [7:0] SBAC_OFS_CTRL   = 8'hB3;
  localparam logic [7:0] SBAC_DATA_RST   = 8'h00;
  localparam logic [7:0] SBAC_INDEX_RST  = 8'h00;
  localparam logic [7:0] SBAC_TARGET_RST = 8'hA0;
  localparam logic [7:0] SBAC_CTRL_RST   = 8'h00;

  // ----------------------------------------------------------------
  // Control and status field positions
  // ----------------------------------------------------------------
  localparam int SBAC_BIT_PHASE   = 7;
  localparam int SBAC_BIT_HBUSY   = 5;
  localparam int SBAC_BIT_PBUSY   = 4;
  localparam int SBAC_BIT_PRESENT = 3;
  localparam int SBAC_BIT_HERR    = 1;
  localparam int SBAC_BIT_PERR    = 0;

  // ----------------------------------------------------------------
  // Preload and timing
  // ----------------------------------------------------------------
  localparam logic [6:0] SBAC_PRELOAD_ADDR = 7'h50;
  localparam logic [7:0] SBAC_PRELOAD_LAST = 8'h0F;
  localparam logic [1:0] SBAC_DETECT_WAIT  = 2'h3;
  localparam int         SBAC_CLK_PERIOD_NS = 8;
  localparam int         SBAC_SCL_PERIOD_NS = 10000;
  localparam logic [8:0] SBAC_QTR_CYCLES =
    9'(SBAC_SCL_PERIOD_NS / (4 * SBAC_CLK_PERIOD_NS));

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [6:0] addr;
    logic       rd;
    logic       addr_only;
    logic [7:0] index;
    logic [7:0] wdata;
  } sbac_req_s;

  typedef struct packed {
    logic       done;
    logic       err;
    logic [7:0] rdata;
  } sbac_rsp_s;

  typedef enum logic [3:0] {
    SBAC_IDLE    = 4'h0,
    SBAC_START   = 4'h1,
    SBAC_ADDR    = 4'h3,
    SBAC_INDEX   = 4'h2,
    SBAC_RESTART = 4'h6,
    SBAC_ADDR2   = 4'h7,
    SBAC_DATA    = 4'h5,
    SBAC_STOP    = 4'h4
  } sbac_state_e;

endpackage

// ### core/sbac_engine.sv
// Purpose: Two-wire bus byte engine, one byte transaction per request
// Assumes: Open-drain pins resolved outside; quarter-bit tick from divider
// Notes:   Target clock stretching honoured while the clock is released
`timescale 1ns/1ps
module sbac_engine
  import sbac_pkg::*;
(
  input  wire logic      core_clk,
  input  wire logic      reset_n,
  input  wire logic      start,
  input  wire sbac_req_s req_in,
  output sbac_rsp_s      rsp,
  output logic           scl_out,
  output logic           scl_oe,
  input  wire logic      scl_in,
  output logic           sda_out,
  output logic           sda_oe,
  input  wire logic      sda_in
);

  sbac_state_e st, next_st;
  sbac_req_s   req, next_req;
  sbac_rsp_s   next_rsp;
  logic [1:0]  q, next_q;
  logic [3:0]  bitn, next_bitn;
  logic [7:0]  sh, next_sh;
  logic [8:0]  div, next_div;
  logic        next_scl_oe, next_sda_oe;
  logic [1:0]  scl_sync, sda_sync;
  logic        tick, adv, tx, byte_st;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign tick    = (div == SBAC_QTR_CYCLES - 9'h001);
  // Hold the high phase while a target stretches the clock
  assign adv     = tick && !(q == 2'h2 && !scl_sync[1]);
  assign tx      = !(st == SBAC_DATA && req.rd);
  assign byte_st = (st == SBAC_ADDR) || (st == SBAC_INDEX) || (st == SBAC_ADDR2) || (st == SBAC_DATA);

  always_comb begin
    next_st     = st;
    next_req    = req;
    next_rsp    = rsp;
    next_rsp.done = 1'b0;
    next_q      = q;
    next_bitn   = bitn;
    next_sh     = sh;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;
    next_div    = tick ? 9'h000 : div + 9'h001;
    if (st == SBAC_IDLE) begin
      next_div    = 9'h000;
      next_q      = 2'h0;
      next_scl_oe = 1'b0;
      next_sda_oe = 1'b0;
      if (start) begin
        next_req     = req_in;
        next_rsp.err = 1'b0;
        next_st      = SBAC_START;
      end
    end else if (adv) begin
      next_q = q + 2'h1;
      unique case (st)
        SBAC_START, SBAC_RESTART: begin
          unique case (q)
            2'h0: next_sda_oe = 1'b0;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b1;
            default: begin
              next_scl_oe = 1'b1;
              next_bitn   = 4'h0;
              if (st == SBAC_RESTART) begin
                next_st = SBAC_ADDR2;
                next_sh = {req.addr, 1'b1};
              end else begin
                next_st = SBAC_ADDR;
                // Read direction goes out at once only with no index phase
                next_sh = {req.addr, req.rd & req.addr_only};
              end
            end
          endcase
        end
        SBAC_STOP: begin
          unique case (q)
            2'h0: next_sda_oe = 1'b1;
            2'h1: next_scl_oe = 1'b0;
            2'h2: next_sda_oe = 1'b0;
            default: begin
              next_st       = SBAC_IDLE;
              next_rsp.done = 1'b1;
            end
          endcase
        end
        SBAC_ADDR, SBAC_INDEX, SBAC_ADDR2, SBAC_DATA: begin
          unique case (q)
            2'h0: begin
              next_scl_oe = 1'b1;
              next_sda_oe = tx && bitn != 4'h8 && !sh[7];
            end
            2'h1: next_scl_oe = 1'b0;
            2'h2: begin
              if (bitn == 4'h8 && tx && sda_sync[1]) begin
                next_rsp.err = 1'b1;
              end else if (!tx && bitn != 4'h8) begin
                next_sh = {sh[6:0], sda_sync[1]};
              end
            end
            default: begin
              next_scl_oe = 1'b1;
              next_bitn   = bitn + 4'h1;
              if (tx && bitn != 4'h8) begin
                next_sh = {sh[6:0], 1'b0};
              end
              if (bitn == 4'h8) begin
                next_bitn = 4'h0;
                if (rsp.err || st == SBAC_DATA) begin
                  next_st = SBAC_STOP;
                  if (!tx) begin
                    next_rsp.rdata = sh;
                  end
                end else if (st == SBAC_ADDR && !req.addr_only) begin
                  next_st = SBAC_INDEX;
                  next_sh = req.index;
                end else if (st == SBAC_INDEX && req.rd) begin
                  next_st = SBAC_RESTART;
                end else begin
                  next_st = SBAC_DATA;
                  next_sh = req.wdata;
                end
              end
            end
          endcase
        end
        default: next_st = SBAC_IDLE;
      endcase
    end
    if (!byte_st && st != SBAC_IDLE && st != SBAC_START && st != SBAC_RESTART && st != SBAC_STOP) begin
      next_st = SBAC_IDLE;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st      <= SBAC_IDLE;
      req     <= '0;
      rsp     <= '0;
      q       <= 2'h0;
      bitn    <= 4'h0;
      sh      <= 8'h00;
      div     <= 9'h000;
      scl_oe  <= 1'b0;
      sda_oe  <= 1'b0;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end else begin
      st      <= next_st;
      req     <= next_req;
      rsp     <= next_rsp;
      q       <= next_q;
      bitn    <= next_bitn;
      sh      <= next_sh;
      div     <= next_div;
      scl_oe  <= next_scl_oe;
      sda_oe  <= next_sda_oe;
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

endmodule

// ### verif/sbac_ctrl_asserts.sv
// Purpose: Port-level assertions for sbac_ctrl
// Assumes: Bound to sbac_ctrl in the bench
// Notes:   Helpers remember the last status read and target write
`timescale 1ns/1ps
module sbac_ctrl_asserts
  import sbac_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       reset_n,
  input wire logic       cfg_wr_en,
  input wire logic       cfg_rd_en,
  input wire logic [7:0] cfg_addr,
  input wire logic [7:0] cfg_wdata,
  input wire logic [7:0] cfg_rdata,
  input wire logic       scl_oe,
  input wire logic       sda_oe
);
  // ------------------------------------
  // Helpers
  // ------------------------------------
  logic       wtg, next_wtg, ph7, next_ph7, rdy, next_rdy, rdq, next_rdq;
  logic [7:0] tg, next_tg;
  wire        wr_t = cfg_wr_en && cfg_addr == SBAC_OFS_TARGET;
  wire        rd_c = cfg_rd_en && cfg_addr == SBAC_OFS_CTRL;

  // Launch only expected after a read showed enabled and idle
  always_comb begin
    next_wtg = wtg | wr_t;
    next_tg = wr_t ? cfg_wdata : tg;
    next_rdq = rd_c;
    next_ph7 = ph7;
    next_rdy = rdq ? (cfg_rdata[5:3] == 3'b001) : rdy;
    if (wr_t) next_rdy = 1'b0;
    if (cfg_wr_en && cfg_addr == SBAC_OFS_CTRL) begin
      next_ph7 = cfg_wdata[7];
      next_rdy = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      {wtg, ph7, rdy, rdq, tg} <= '0;
    end else begin
      {wtg, ph7, rdy, rdq, tg} <= {next_wtg, next_ph7, next_rdy, next_rdq, next_tg};
    end
  end

  // ------------------------------------
  // Properties
  // ------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  a_rsvd_zero: assert property (rd_c |=> !cfg_rdata[6] && !cfg_rdata[2])
    else $error("reserved bit set");
  a_target_default: assert property (cfg_rd_en && cfg_addr == SBAC_OFS_TARGET && !wtg |=> cfg_rdata == 8'hA0)
    else $error("target default wrong");
  a_target_readback: assert property (cfg_rd_en && cfg_addr == SBAC_OFS_TARGET && wtg |=> cfg_rdata == tg)
    else $error("target readback wrong");
  a_phase_readback: assert property (rd_c |=> cfg_rdata[7] == ph7)
    else $error("phase bit wrong");
  a_launch_start: assert property (wr_t && rdy |-> ##[1:1000] sda_oe)
    else $error("no start after launch");
  a_busy_shows: assert property ((wr_t && rdy) ##2 rd_c |=> cfg_rdata[5])
    else $error("busy not shown");
  a_idle_released: assert property (rd_c ##1 cfg_rdata[5:4] == 2'b00 |-> !scl_oe && !sda_oe)
    else $error("bus driven while idle");
  a_error_clears: assert property (rd_c ##1 (rd_c && cfg_rdata[5:4] == 2'b00) |=> cfg_rdata[1:0] == 2'b00)
    else $error("error not cleared");

  c_launch: cover property (wr_t && rdy);
  c_error: cover property (rd_c ##1 cfg_rdata[1]);
  c_preload: cover property (rd_c ##1 cfg_rdata[4]);
endmodule

// ### verif/sbac_prom_model.sv
// Purpose: Behavioural two-wire target with one byte of storage
// Assumes: Lines resolved with pull-ups in the bench
// Notes:   Reads return the last written byte
`timescale 1ns/1ps
module sbac_prom_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic [6:0] dev_addr,
  input  wire logic       stretch,
  output logic            scl_pull,
  output logic            sda_pull,
  output logic      [7:0] first_byte,
  output logic      [7:0] last_byte,
  output int              wr_count
);
  logic [7:0] sh = 8'h00;
  logic [7:0] outb = 8'h00;
  logic       act = 1'b0;
  logic       sel = 1'b0;
  logic       rdm = 1'b0;
  int         bitc = 0;
  int         nb = 0;

  initial begin
    {scl_pull, sda_pull, first_byte, last_byte} = '0;
    wr_count = 0;
  end
  // ------------------------------------
  // Framing
  // ------------------------------------
  always @(negedge sda) begin
    if (scl === 1'b1) begin
      act = 1'b1;
      bitc = 0;
      nb = 0;
    end
  end
  always @(posedge sda) begin
    if (scl === 1'b1) act = 1'b0;
  end
  always @(posedge scl) begin
    if (act && bitc < 8) begin
      sh = {sh[6:0], sda};
      bitc++;
    end
  end
  // Data only moves while the clock is low
  always @(negedge scl) begin
    if (act && bitc == 8) begin
      bitc = 9;
      nb++;
      if (nb == 1) begin
        sel = sh[7:1] === dev_addr;
        rdm = sh[0];
        if (sel) wr_count = 0;
      end else if (!rdm) begin
        if (nb == 2) first_byte = sh;
        last_byte = sh;
        wr_count++;
      end
      sda_pull = sel && !(rdm && nb > 1);
      if (stretch) begin
        scl_pull = 1'b1;
        // Outlasts the master's low-phase quarters so it has to wait
        #9000 scl_pull = 1'b0;
      end
    end else if (act && bitc == 9) begin
      bitc = 0;
      sda_pull = 1'b0;
      if (!sel || (rdm && nb > 1)) act = 1'b0;
      else if (rdm) begin
        outb = last_byte;
        sda_pull = !outb[7];
      end
    end else if (act && sel && rdm && nb > 0) begin
      sda_pull = !outb[7 - bitc];
    end
  end
endmodule

// ### verif/tb_top.sv
// Purpose: Self-checking bench for sbac_ctrl
// Assumes: Pull-ups on both bus lines
// Notes:   Target address never equals the preload address, so preload aborts
`timescale 1ns/1ps
module tb_top
  import sbac_pkg::*;
;
  logic       core_clk, reset_n, global_reset_n, prom_strap, cfg_wr_en, cfg_rd_en, stretch;
  logic       scl_oe, sda_oe, m_scl, m_sda, pv, scl_o, sda_o;
  logic [7:0] cfg_addr, cfg_wdata, cfg_rdata, first_b, last_b, idx, dat, p_idx, p_dat;
  logic [6:0] dev;
  int         seed, wr_cnt, fail_count, n_tests, pv_cnt;
  wire        scl = ~(scl_oe | m_scl);
  wire        sda = ~(sda_oe | m_sda);

  sbac_ctrl DUT (.core_clk(core_clk), .reset_n(reset_n), .global_reset_n(global_reset_n),
    .prom_strap(prom_strap), .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .scl_out(scl_o), .scl_oe(scl_oe), .scl_in(scl),
    .sda_out(sda_o), .sda_oe(sda_oe), .sda_in(sda), .preload_valid(pv),
    .preload_index(p_idx), .preload_data(p_dat));
  sbac_prom_model u_prom (.scl(scl), .sda(sda), .dev_addr(dev), .stretch(stretch), .scl_pull(m_scl),
    .sda_pull(m_sda), .first_byte(first_b), .last_byte(last_b), .wr_count(wr_cnt));

  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) if (pv === 1'b1) pv_cnt++;

  // ------------------------------------
  // Tasks
  // ------------------------------------
  task automatic end_sim;
    if (fail_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Status byte from phase, busy, preload, present, error and load error
  function automatic logic [7:0] sts(input logic [5:0] f);
    sts = 8'h00;
    {sts[SBAC_BIT_PHASE], sts[SBAC_BIT_HBUSY], sts[SBAC_BIT_PBUSY], sts[SBAC_BIT_PRESENT], sts[SBAC_BIT_HERR],
      sts[SBAC_BIT_PERR]} = f;
  endfunction
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    n_tests++;
    if (s !== e) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // Idle cycle after each strobe keeps drivers race-free
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    {cfg_addr, cfg_wdata, cfg_wr_en} = {a, d, 1'b1};
    @(posedge core_clk) #1 cfg_wr_en = 1'b0;
    @(posedge core_clk) #1;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    {cfg_addr, cfg_rd_en} = {a, 1'b1};
    @(posedge core_clk) #1 cfg_rd_en = 1'b0;
    @(posedge core_clk) #1 chk(cfg_rdata, e);
  endtask
  // Idle means no line pulled for over a bit time
  task automatic wait_bus;
    int q;
    q = 0;
    for (int n = 0; n < 60000 && q < 1400; n++) begin
      @(posedge core_clk) #1;
      q = (scl_oe | sda_oe) ? 0 : q + 1;
    end
    if (q < 1400) begin
      fail_count++;
      end_sim;
    end
  endtask

  initial begin
    // Preload, three host cycles and idle gaps come to about 96k cycles
    #800000 fail_count++;
    end_sim;
  end

  // ------------------------------------
  // Scenarios
  // ------------------------------------
  initial begin
    {core_clk, reset_n, cfg_wr_en, cfg_rd_en, stretch} = '0;
    {global_reset_n, prom_strap} = 2'b11;
    {cfg_addr, cfg_wdata} = '0;
    {fail_count, n_tests, pv_cnt} = '0;
    seed = 36;
    dev = {2'b01, 5'($random(seed))};
    idx = 8'($random(seed));
    dat = 8'($random(seed));
    repeat (16) @(posedge core_clk);
    #1 reset_n = 1'b1;
    repeat (20) @(posedge core_clk);
    #1 rd_chk(SBAC_OFS_CTRL, sts(6'b001100));
    rd_chk(SBAC_OFS_TARGET, 8'hA0);
    rd_chk(SBAC_OFS_DATA, 8'h00);
    rd_chk(SBAC_OFS_INDEX, 8'h00);
    rd_chk(8'hB5, 8'h00);
    wait_bus;
    rd_chk(SBAC_OFS_CTRL, sts(6'b000101));
    {cfg_addr, cfg_rd_en} = {SBAC_OFS_CTRL, 1'b1};
    repeat (2) @(posedge core_clk);
    #1 cfg_rd_en = 1'b0;
    @(posedge core_clk) #1 chk(cfg_rdata, sts(6'b000100));
    chk(8'(pv_cnt), 8'h00);
    chk(p_idx | p_dat, 8'h00);
    prom_strap = 1'b0;
    repeat (10) @(posedge core_clk);
    #1 rd_chk(SBAC_OFS_CTRL, sts(6'b000100));
    global_reset_n = 1'b0;
    repeat (4) @(posedge core_clk);
    #1 global_reset_n = 1'b1;
    repeat (10) @(posedge core_clk);
    #1 rd_chk(SBAC_OFS_CTRL, sts(6'b000000));
    wr(SBAC_OFS_TARGET, {dev, 1'b0});
    // Past the third quarter, where a wrong launch would pull the data line
    repeat (1000) @(posedge core_clk);
    #1 chk({4'h0, scl_o, sda_o, scl_oe, sda_oe}, 8'h00);
    rd_chk(SBAC_OFS_TARGET, {dev, 1'b0});
    wr(SBAC_OFS_CTRL, 8'h08);
    wr(SBAC_OFS_INDEX, idx);
    wr(SBAC_OFS_DATA, dat);
    rd_chk(SBAC_OFS_CTRL, sts(6'b000100));
    stretch = 1'b1;
    wr(SBAC_OFS_TARGET, {dev, 1'b0});
    rd_chk(SBAC_OFS_CTRL, sts(6'b010100));
    wait_bus;
    rd_chk(SBAC_OFS_CTRL, sts(6'b000100));
    chk(first_b, idx);
    chk(last_b, dat);
    chk(8'(wr_cnt), 8'h02);
    stretch = 1'b0;
    wr(SBAC_OFS_CTRL, 8'h88);
    rd_chk(SBAC_OFS_CTRL, sts(6'b100100));
    wr(SBAC_OFS_TARGET, {dev, 1'b1});
    rd_chk(SBAC_OFS_CTRL, sts(6'b110100));
    wait_bus;
    rd_chk(SBAC_OFS_CTRL, sts(6'b100100));
    rd_chk(SBAC_OFS_DATA, dat);
    wr(SBAC_OFS_TARGET, {dev ^ 7'h01, 1'b1});
    wait_bus;
    rd_chk(SBAC_OFS_CTRL, sts(6'b100110));
    rd_chk(SBAC_OFS_CTRL, sts(6'b100100));
    end_sim;
  end
endmodule

bind sbac_ctrl sbac_ctrl_asserts u_asserts (.core_clk(core_clk), .reset_n(reset_n),
  .cfg_wr_en(cfg_wr_en), .cfg_rd_en(cfg_rd_en), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
  .cfg_rdata(cfg_rdata), .scl_oe(scl_oe), .sda_oe(sda_oe));
